// File: hw/tsp_consts.svh
// Constants of the transceiver serial data port: register offsets,
// reset values, mode codes, interrupt bit positions and timing counts.
// Assumes a 20 MHz block clock and an 8-bit register port.
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

// Register port geometry and offsets
`define TSP_ADDR_W          12
`define TSP_DATA_W          8
`define TSP_ADDR_RADIO_CFG  12'h13E
`define TSP_ADDR_PIN_CFG    12'h32C
`define TSP_ADDR_IRQ_STAT   12'h340
`define TSP_ADDR_IRQ_MASK   12'h341
`define TSP_ADDR_PORT_STATE 12'h342

// Reset values
`define TSP_RESET_RADIO_CFG 8'h00
`define TSP_RESET_PIN_CFG   8'h00
`define TSP_RESET_IRQ_MASK  4'h0

// Radio mode select codes
`define TSP_RMODE_PKT154    8'h00
`define TSP_RMODE_SER154    8'h02
`define TSP_RMODE_SERFSK    8'h03

// Port function select codes
`define TSP_PFN_OFF         8'h00
`define TSP_PFN_FREE_F      8'h01
`define TSP_PFN_PRE_F       8'h02
`define TSP_PFN_SYNC_F      8'h03
`define TSP_PFN_FREE_R      8'h04
`define TSP_PFN_PRE_R       8'h05
`define TSP_PFN_SYNC_R      8'h06
`define TSP_PFN_SYMCLK      8'h07

// Interrupt status bit positions
`define TSP_IRQ_W           4
`define TSP_IRQ_PREAMBLE    0
`define TSP_IRQ_SYNC        1
`define TSP_IRQ_RX_PKT      2
`define TSP_IRQ_TX_PKT      3

// Symbol width and timing
`define TSP_SYM_W           4
`define TSP_CLK_NS          50
`define TSP_LINK_PERIOD_NS  400
`define TSP_HALF_CYC        (((`TSP_LINK_PERIOD_NS / 2) + `TSP_CLK_NS - 1) / `TSP_CLK_NS)
`define TSP_HALF_W          4
`define TSP_SYMCLK_HIGH_NS  1000
`define TSP_SYMCLK_CYC      ((`TSP_SYMCLK_HIGH_NS + `TSP_CLK_NS - 1) / `TSP_CLK_NS)
`define TSP_SYMCLK_W        6

`endif

// File: hw/tsp_pkg.sv
// Types shared by the serial data port modules.
// Assumes tsp_consts.svh is on the include path.
`include "tsp_consts.svh"

package tsp_pkg;

  // Port sequencer states
  typedef enum logic [2:0] {
    TSP_ST_IDLE,
    TSP_ST_RX_WAIT,
    TSP_ST_RX_STREAM,
    TSP_ST_TX_WAIT,
    TSP_ST_TX_STREAM
  } tsp_state_e;

  // Status and data from the radio core, all on clk_i
  typedef struct packed {
    logic                  rx_state;
    logic                  tx_state;
    logic                  receive_command;
    logic                  tx_mac_done;
    logic                  rx_bit;
    logic                  preamble_det;
    logic                  sync_det;
    logic                  sfd_det;
    logic                  rx_pkt_done;
    logic                  tx_pkt_done;
    logic                  symbol_valid;
    logic [`TSP_SYM_W-1:0] symbol;
    logic                  rx_enable_a;
    logic                  rx_enable_b;
  } tsp_core_s;

  // Answers to the radio core
  typedef struct packed {
    logic rx_bit_take;
    logic tx_bit;
    logic tx_bit_valid;
  } tsp_core_out_s;

  // Pin side outputs
  typedef struct packed {
    logic port_clock_out;
    logic port_rx_data_out;
    logic port_frame_out;
    logic port_tx_data_in_drive;
    logic port_tx_data_in_oe;
    logic rx_enable_pin_a;
    logic rx_enable_pin_b;
  } tsp_pins_s;

endpackage

// File: hw/tsp_sync2.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to clk_i.
module tsp_sync2 (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Level in and out
  input  wire logic d_i,
  output logic      q_o
);

  logic meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// File: hw/tsp_clkgen.sv
// Data clock divider for the serial port pins.
// Assumes run_i comes from logic on clk_i; clock idles low when stopped.
`include "tsp_consts.svh"

module tsp_clkgen (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Control
  input  wire logic run_i,
  // Divided clock and edge pulses
  output logic      clk_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic [`TSP_HALF_W-1:0] cnt;

  // Half period counter; pulses line up with the new clock level
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt    <= '0;
      clk_o  <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else if (!run_i)
    begin
      cnt    <= '0;
      clk_o  <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
    else if (cnt == `TSP_HALF_W'(`TSP_HALF_CYC - 1))
    begin
      cnt    <= '0;
      clk_o  <= ~clk_o;
      rise_o <= ~clk_o;
      fall_o <= clk_o;
    end
    else
    begin
      cnt    <= cnt + `TSP_HALF_W'(1);
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
  end

endmodule

// File: hw/tsp_serial_port.sv
// Serial data port of the transceiver: register port, stream sequencer,
// pin multiplexing, symbol clock option and interrupt status.
// Assumes core_i is synchronous to clk_i and detector flags are pulses.
`include "tsp_consts.svh"

// Notes on behaviour
// RL1: Host sets radio mode three for serial.
// RL2: Port function select picks the configuration.
// RL3: Host loads sync detector before receiving.
// RL4: Streaming lasts until command or receive exit.
// RL5: Free configurations: clock at once, frame low.
// RL6: Preamble gating; frame high on sync match.
// RL7: Sync gating; first edge carries next bit.
// RL8: Host ignores data before first clock edge.
// RL9: Configurations one to three launch on fall.
// RL10: Configurations four to six launch on rise.
// RL11: Serial 15.4 receive starts on delimiter.
// RL12: No packet received interrupt in serial 15.4.
// RL13: Function seven gives symbol clock in packet mode.
// RL14: Four symbol bits presented on four pins.
// RL15: Host spreads chips itself, clocked by device.
// RL16: Transmit sample edge from function; no sent irq.
// RL17: Transmit clock starts after transmit delay.
// RL18: Framing pin drops interrupt role when enabled.
// RL19: Idle clock and data held low.
module tsp_serial_port (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  // Register port
  input  wire logic [`TSP_ADDR_W-1:0]   reg_addr_i,
  input  wire logic [`TSP_DATA_W-1:0]   reg_wdata_i,
  input  wire logic                     reg_write_i,
  input  wire logic                     reg_read_i,
  output logic      [`TSP_DATA_W-1:0]   reg_rdata_o,
  // Radio core side
  input  wire tsp_pkg::tsp_core_s       core_i,
  output tsp_pkg::tsp_core_out_s        core_o,
  // Pins
  input  wire logic                     port_tx_data_in_i,
  output tsp_pkg::tsp_pins_s            pins_o,
  // Interrupt
  output logic                          irq_o
);

  logic [`TSP_DATA_W-1:0] radio_controller_config;
  logic [`TSP_DATA_W-1:0] pin_function_config;
  logic [`TSP_IRQ_W-1:0]  irq_stat;
  logic [`TSP_IRQ_W-1:0]  irq_mask;
  logic [`TSP_IRQ_W-1:0]  irq_event;
  tsp_pkg::tsp_state_e    state;
  tsp_pkg::tsp_state_e    next_state;
  logic                   fall_group;
  logic                   rise_group;
  logic                   sync_group;
  logic                   free_group;
  logic                   ser_rx_en;
  logic                   ser_tx_en;
  logic                   sym_en;
  logic                   port_en;
  logic                   start_cond;
  logic                   enter_rx;
  logic                   launch;
  logic                   tx_sample;
  logic                   rx_active;
  logic                   clk_lvl;
  logic                   clk_rise;
  logic                   clk_fall;
  logic                   tx_pin_sync;
  logic                   rx_data_q;
  logic                   frame_q;
  logic                   tx_bit_q;
  logic                   tx_valid_q;
  logic [`TSP_SYM_W-1:0]  sym_q;
  logic [`TSP_SYMCLK_W-1:0] sym_cnt;

  // Transmit pin comes from the host's clock domain
  tsp_sync2 u_tx_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (port_tx_data_in_i),
    .q_o     (tx_pin_sync)
  );

  // Data clock runs only while a stream is live
  tsp_clkgen u_clkgen (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .run_i   ((state == tsp_pkg::TSP_ST_RX_STREAM) || (state == tsp_pkg::TSP_ST_TX_STREAM)),
    .clk_o   (clk_lvl),
    .rise_o  (clk_rise),
    .fall_o  (clk_fall)
  );

  // RL2: configuration decode
  assign fall_group = (pin_function_config == `TSP_PFN_FREE_F) ||
                      (pin_function_config == `TSP_PFN_PRE_F) ||
                      (pin_function_config == `TSP_PFN_SYNC_F);
  assign rise_group = (pin_function_config == `TSP_PFN_FREE_R) ||
                      (pin_function_config == `TSP_PFN_PRE_R) ||
                      (pin_function_config == `TSP_PFN_SYNC_R);
  assign sync_group = (pin_function_config == `TSP_PFN_PRE_F) ||
                      (pin_function_config == `TSP_PFN_SYNC_F) ||
                      (pin_function_config == `TSP_PFN_PRE_R) ||
                      (pin_function_config == `TSP_PFN_SYNC_R);
  assign free_group = (pin_function_config == `TSP_PFN_FREE_F) ||
                      (pin_function_config == `TSP_PFN_FREE_R);
  assign port_en    = (pin_function_config != `TSP_PFN_OFF) &&
                      (pin_function_config <= `TSP_PFN_SYMCLK);

  // RL11: serial 15.4 receive uses function one only
  assign ser_rx_en = core_i.rx_state &&
                     (((radio_controller_config == `TSP_RMODE_SERFSK) && (fall_group || rise_group)) ||
                      ((radio_controller_config == `TSP_RMODE_SER154) &&
                       (pin_function_config == `TSP_PFN_FREE_F)));
  // RL16: transmit needs function one or four
  assign ser_tx_en = core_i.tx_state && free_group &&
                     (radio_controller_config == `TSP_RMODE_SERFSK);
  // RL13: symbol clock only in 15.4 packet mode
  assign sym_en    = core_i.rx_state && (pin_function_config == `TSP_PFN_SYMCLK) &&
                     (radio_controller_config == `TSP_RMODE_PKT154);
  assign rx_active = (state == tsp_pkg::TSP_ST_RX_WAIT) || (state == tsp_pkg::TSP_ST_RX_STREAM);

  // Gating event that opens the receive stream
  always_comb
  begin
    start_cond = 1'b1;
    if ((pin_function_config == `TSP_PFN_PRE_F) || (pin_function_config == `TSP_PFN_PRE_R))
    begin
      // RL6: preamble gating
      start_cond = core_i.preamble_det;
    end
    else if ((pin_function_config == `TSP_PFN_SYNC_F) ||
             (pin_function_config == `TSP_PFN_SYNC_R))
    begin
      // RL7: sync word gating
      start_cond = core_i.sync_det;
    end
    else if (radio_controller_config == `TSP_RMODE_SER154)
    begin
      // RL11: start on frame delimiter
      start_cond = core_i.sfd_det;
    end
  end

  // Stream sequencer next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      tsp_pkg::TSP_ST_IDLE:
      begin
        if (ser_rx_en)
          next_state = tsp_pkg::TSP_ST_RX_WAIT;
        else if (ser_tx_en)
          next_state = tsp_pkg::TSP_ST_TX_WAIT;
      end
      tsp_pkg::TSP_ST_RX_WAIT:
      begin
        // RL5: free configurations start at once outside serial 15.4
        if (!ser_rx_en)
          next_state = tsp_pkg::TSP_ST_IDLE;
        else if (start_cond && !core_i.receive_command)
          next_state = tsp_pkg::TSP_ST_RX_STREAM;
      end
      tsp_pkg::TSP_ST_RX_STREAM:
      begin
        // RL4: stop only on reissue or exit
        if (!ser_rx_en)
          next_state = tsp_pkg::TSP_ST_IDLE;
        else if (core_i.receive_command)
          next_state = tsp_pkg::TSP_ST_RX_WAIT;
      end
      tsp_pkg::TSP_ST_TX_WAIT:
      begin
        // RL17: wait out transmit delay
        if (!ser_tx_en)
          next_state = tsp_pkg::TSP_ST_IDLE;
        else if (core_i.tx_mac_done)
          next_state = tsp_pkg::TSP_ST_TX_STREAM;
      end
      tsp_pkg::TSP_ST_TX_STREAM:
      begin
        if (!ser_tx_en)
          next_state = tsp_pkg::TSP_ST_IDLE;
      end
      default:
      begin
        next_state = tsp_pkg::TSP_ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      state <= tsp_pkg::TSP_ST_IDLE;
    else
      state <= next_state;
  end

  // Falling-launch modes load the first bit before the first rise
  assign enter_rx = (state == tsp_pkg::TSP_ST_RX_WAIT) &&
                    (next_state == tsp_pkg::TSP_ST_RX_STREAM);
  // RL9: launch on falling edge
  // RL10: launch on rising edge
  assign launch   = ((state == tsp_pkg::TSP_ST_RX_STREAM) && (fall_group ? clk_fall : clk_rise)) ||
                    (enter_rx && fall_group);

  // Receive data register
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rx_data_q <= 1'b0;
    else if ((state != tsp_pkg::TSP_ST_RX_STREAM) && !enter_rx)
      // RL19: static low when idle
      rx_data_q <= 1'b0;
    else if (launch)
      rx_data_q <= core_i.rx_bit;
  end

  // Framing flag; a sync match in the clearing cycle still sets it
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      frame_q <= 1'b0;
    else if (sync_group && rx_active && ser_rx_en && core_i.sync_det)
      // RL6: high at sync match
      frame_q <= 1'b1;
    else if (!sync_group || !rx_active || core_i.receive_command)
      // RL5: unused framing held low
      frame_q <= 1'b0;
  end

  // RL16: sample edge follows function select
  assign tx_sample = (state == tsp_pkg::TSP_ST_TX_STREAM) &&
                     ((pin_function_config == `TSP_PFN_FREE_F) ? clk_rise : clk_fall);

  // Transmit bit capture; the pin path is two cycles late, inside half a period
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_bit_q   <= 1'b0;
      tx_valid_q <= 1'b0;
    end
    else
    begin
      tx_valid_q <= tx_sample;
      if (tx_sample)
        tx_bit_q <= tx_pin_sync;
    end
  end

  // Symbol nibble and symbol clock pulse
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sym_q   <= '0;
      sym_cnt <= '0;
    end
    else if (!sym_en)
    begin
      sym_q   <= '0;
      sym_cnt <= '0;
    end
    else if (core_i.symbol_valid)
    begin
      // RL14: latch four symbol bits
      sym_q   <= core_i.symbol;
      sym_cnt <= `TSP_SYMCLK_W'(`TSP_SYMCLK_CYC);
    end
    else if (sym_cnt != '0)
      sym_cnt <= sym_cnt - `TSP_SYMCLK_W'(1);
  end

  // RL12: no packet received event in serial 15.4
  // RL16: no packet sent event in serial transmit
  assign irq_event[`TSP_IRQ_PREAMBLE] = core_i.preamble_det;
  assign irq_event[`TSP_IRQ_SYNC]     = core_i.sync_det;
  assign irq_event[`TSP_IRQ_RX_PKT]   = core_i.rx_pkt_done &&
                                        (radio_controller_config != `TSP_RMODE_SER154);
  assign irq_event[`TSP_IRQ_TX_PKT]   = core_i.tx_pkt_done &&
                                        (radio_controller_config != `TSP_RMODE_SERFSK);

  // Sticky status, write one to clear; a new event beats the clear
  for (genvar gi = 0; gi < `TSP_IRQ_W; gi++)
  begin : g_irq
    always_ff @(posedge clk_i or posedge reset_i)
    begin
      if (reset_i)
        irq_stat[gi] <= 1'b0;
      else if (irq_event[gi])
        irq_stat[gi] <= 1'b1;
      else if (reg_write_i && (reg_addr_i == `TSP_ADDR_IRQ_STAT) && reg_wdata_i[gi])
        irq_stat[gi] <= 1'b0;
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // Writable configuration registers
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      radio_controller_config <= `TSP_RESET_RADIO_CFG;
      pin_function_config     <= `TSP_RESET_PIN_CFG;
      irq_mask                <= `TSP_RESET_IRQ_MASK;
    end
    else if (reg_write_i)
    begin
      if (reg_addr_i == `TSP_ADDR_RADIO_CFG)
        radio_controller_config <= reg_wdata_i;
      if (reg_addr_i == `TSP_ADDR_PIN_CFG)
        pin_function_config <= reg_wdata_i;
      if (reg_addr_i == `TSP_ADDR_IRQ_MASK)
        irq_mask <= reg_wdata_i[`TSP_IRQ_W-1:0];
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      reg_rdata_o <= '0;
    else if (!reg_read_i)
      reg_rdata_o <= '0;
    else
    begin
      unique case (reg_addr_i)
        `TSP_ADDR_RADIO_CFG:   reg_rdata_o <= radio_controller_config;
        `TSP_ADDR_PIN_CFG:     reg_rdata_o <= pin_function_config;
        `TSP_ADDR_IRQ_STAT:    reg_rdata_o <= {4'h0, irq_stat};
        `TSP_ADDR_IRQ_MASK:    reg_rdata_o <= {4'h0, irq_mask};
        `TSP_ADDR_PORT_STATE:  reg_rdata_o <= {4'h0, sym_en, frame_q,
                                               state == tsp_pkg::TSP_ST_TX_STREAM,
                                               state == tsp_pkg::TSP_ST_RX_STREAM};
        default:               reg_rdata_o <= '0;
      endcase
    end
  end

  // Core answers
  assign core_o.rx_bit_take  = launch;
  assign core_o.tx_bit       = tx_bit_q;
  assign core_o.tx_bit_valid = tx_valid_q;

  // RL14: symbol bits onto the four pins
  assign pins_o.port_clock_out        = sym_en ? (sym_cnt != '0) : clk_lvl;
  assign pins_o.port_rx_data_out      = sym_en ? sym_q[0] : rx_data_q;
  assign pins_o.port_tx_data_in_drive = sym_q[1];
  assign pins_o.port_tx_data_in_oe    = sym_en;
  assign pins_o.rx_enable_pin_a       = sym_en ? sym_q[2] : core_i.rx_enable_a;
  assign pins_o.rx_enable_pin_b       = sym_en ? sym_q[3] : core_i.rx_enable_b;
  // RL18: framing pin drops interrupt role
  assign pins_o.port_frame_out        = port_en ? frame_q : irq_o;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  property p_free_frame_low;
    free_group |-> !frame_q;
  endproperty
  a_free_frame_low: assert property (p_free_frame_low) // RL5
    else $error("framing flag high in a free-running configuration");

  property p_idle_low;
    (state == tsp_pkg::TSP_ST_IDLE)[*2] ##0 !sym_en |-> !pins_o.port_clock_out && !rx_data_q;
  endproperty
  a_idle_low: assert property (p_idle_low) // RL19
    else $error("clock or data not low while idle");

  property p_sync_gate;
    ((pin_function_config == `TSP_PFN_SYNC_F) || (pin_function_config == `TSP_PFN_SYNC_R)) &&
    (state == tsp_pkg::TSP_ST_RX_WAIT) && !core_i.sync_det
      |=> (state != tsp_pkg::TSP_ST_RX_STREAM) && !clk_lvl;
  endproperty
  a_sync_gate: assert property (p_sync_gate) // RL7
    else $error("stream opened without sync word");

  property p_pre_start;
    ((pin_function_config == `TSP_PFN_PRE_F) || (pin_function_config == `TSP_PFN_PRE_R)) &&
    (state == tsp_pkg::TSP_ST_RX_WAIT) && ser_rx_en && core_i.preamble_det &&
    !core_i.receive_command
      |=> (state == tsp_pkg::TSP_ST_RX_STREAM) ##[4:5] clk_rise;
  endproperty
  a_pre_start: assert property (p_pre_start) // RL6
    else $error("preamble did not start the data clock");

  property p_frame_set;
    sync_group && rx_active && ser_rx_en && core_i.sync_det |=> frame_q;
  endproperty
  a_frame_set: assert property (p_frame_set) // RL6
    else $error("framing flag missed the sync match");

  property p_keep_stream;
    (state == tsp_pkg::TSP_ST_RX_STREAM) && ser_rx_en && !core_i.receive_command
      |=> state == tsp_pkg::TSP_ST_RX_STREAM;
  endproperty
  a_keep_stream: assert property (p_keep_stream) // RL4
    else $error("stream ended without command or exit");

  property p_fall_launch;
    fall_group && $changed(rx_data_q) && (state == tsp_pkg::TSP_ST_RX_STREAM) &&
    ($past(state) == tsp_pkg::TSP_ST_RX_STREAM) |-> $past(clk_fall) && !clk_lvl;
  endproperty
  a_fall_launch: assert property (p_fall_launch) // RL9
    else $error("receive data changed away from falling edge");

  property p_rise_launch;
    rise_group && $changed(rx_data_q) && (state == tsp_pkg::TSP_ST_RX_STREAM)
      |-> $past(clk_rise) && clk_lvl;
  endproperty
  a_rise_launch: assert property (p_rise_launch) // RL10
    else $error("receive data changed away from rising edge");

  property p_tx_wait;
    (state == tsp_pkg::TSP_ST_TX_WAIT) |-> !clk_lvl && !tx_valid_q;
  endproperty
  a_tx_wait: assert property (p_tx_wait) // RL17
    else $error("transmit clock before delay elapsed");

  property p_no_rx_pkt;
    (radio_controller_config == `TSP_RMODE_SER154) && !irq_stat[`TSP_IRQ_RX_PKT]
      |=> !irq_stat[`TSP_IRQ_RX_PKT];
  endproperty
  a_no_rx_pkt: assert property (p_no_rx_pkt) // RL12
    else $error("packet received status set in serial mode");

  property p_symbol;
    sym_en && core_i.symbol_valid |=> (sym_q == $past(core_i.symbol)) && pins_o.port_clock_out;
  endproperty
  a_symbol: assert property (p_symbol) // RL14
    else $error("symbol bits or symbol clock wrong");

endmodule

// File: tb/tsp_host_model.sv
// Host serial port model: drives the transmit pin from a fixed pattern.
// Assumes the device owns the data clock; idle line shows inverted bit.
module tsp_host_model (
  // Device clock and mode
  input  wire logic       port_clock_i,
  input  wire logic       launch_fall_i,
  input  wire logic       enable_i,
  input  wire logic [7:0] pattern_i,
  // Transmit pin
  output logic            tx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  // host supplies chips; first bit ready before first sample edge
  always @(posedge enable_i)
  begin
    idx = launch_fall_i ? 1 : 0;
    tx_o = pattern_i[0];
  end
  always @(port_clock_i)
    if (enable_i && port_clock_i !== launch_fall_i)
    begin
      tx_o = pattern_i[idx % 8];
      idx++;
    end
  // Released line must not look like valid data
  always @(negedge enable_i)
    tx_o = ~tx_o;
endmodule

// File: tb/testbench.sv
// Bench: registers, receive modes 1 to 6, transmit, symbol clock, irq.
// Assumes hw/ on the include path; expectations from a queue model.
`include "tsp_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] a_rc = `TSP_ADDR_RADIO_CFG;
  localparam logic [11:0] a_pin = `TSP_ADDR_PIN_CFG;
  localparam logic [11:0] a_st = `TSP_ADDR_IRQ_STAT;
  localparam logic [11:0] a_mk = `TSP_ADDR_IRQ_MASK;
  localparam logic [7:0]  pat = 8'hb4;
  logic                   clk_i, reset_i, we, re, rx_st, tx_st, rx_on, samp_rise, pclk_q;
  logic                   irq, tx_pin, pin_in, fall_lnch;
  logic [11:0]            addr;
  logic [7:0]             wd, rdata, ev;
  logic [16:0]            seed;
  logic [3:0]             s;
  logic                   q[$];
  int                     err_total, total_checks, k;
  tsp_pkg::tsp_core_s     core;
  tsp_pkg::tsp_core_out_s cout;
  tsp_pkg::tsp_pins_s     pins;
  // Core inputs: events, random bit, symbol and enables
  assign core = {rx_st, tx_st, ev[7:6], seed[0], ev[5:0], seed[4:1], seed[6:5]};
  assign pin_in = pins.port_tx_data_in_oe ? pins.port_tx_data_in_drive : tx_pin;
  tsp_serial_port u_tsp_serial_port (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdata), .core_i(core),
    .core_o(cout), .port_tx_data_in_i(pin_in), .pins_o(pins), .irq_o(irq));
  tsp_host_model u_tsp_host_model (.port_clock_i(pins.port_clock_out),
    .launch_fall_i(fall_lnch), .enable_i(tx_st), .pattern_i(pat), .tx_o(tx_pin));
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    @(negedge clk_i);
    chk(rdata, exp);
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 8'h00;
  endtask
  task automatic rx_run(input logic [7:0] p);
    wr(a_rc, 8'h03);
    wr(a_pin, p);
    samp_rise = (p < 4);
    rx_st <= 1'b1;
    rx_on = 1'b1;
    pulse(8'h20);
    repeat (12) @(posedge clk_i);
    pulse(8'h10);
    @(negedge clk_i);
    chk(pins.port_frame_out, p != 1 && p != 4);
    repeat (60) @(posedge clk_i);
    pulse(8'h80);
    rx_on = 1'b0;
    q.delete();
    rd(`TSP_ADDR_PORT_STATE, {7'h00, p == 1 || p == 4});
    @(posedge clk_i);
    rx_st <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({pins.port_clock_out, pins.port_rx_data_out, pins.port_frame_out}, 8'h00);
    $display("rx test %0d done", p);
  endtask
  task automatic tx_run(input logic [7:0] p);
    wr(a_st, 8'h0f);
    wr(a_rc, 8'h03);
    wr(a_pin, p);
    fall_lnch = (p == 1);
    k = 0;
    tx_st <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(pins.port_clock_out, 8'h00);
    pulse(8'h42);
    repeat (80) @(posedge clk_i);
    tx_st <= 1'b0;
    chk(k > 6, 8'h01);
    rd(a_st, 8'h00);
    $display("tx test %0d done", p);
  endtask
  // Block clock, 50 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Random source advances every cycle
  always @(posedge clk_i)
    seed <= lfsr(seed);
  // Reference model: bits queued when taken, compared at sampling edges
  always @(negedge clk_i)
  begin
    if (rx_on && pins.port_clock_out !== pclk_q && pins.port_clock_out === samp_rise)
      chk(pins.port_rx_data_out, q.size() ? q.pop_front() : 1'bx);
    if (rx_on && cout.rx_bit_take)
      q.push_back(core.rx_bit);
    if (tx_st && cout.tx_bit_valid)
    begin
      chk(cout.tx_bit, pat[k % 8]);
      k++;
    end
    pclk_q = pins.port_clock_out;
  end
  // Hang guard
  initial
  begin
    #2_000_000;
    err_total++;
    test_done();
  end
  initial
  begin
    {reset_i, we, re, rx_st, tx_st, rx_on, samp_rise, pclk_q, fall_lnch} = 9'h100;
    {addr, wd, ev, err_total, total_checks, k} = '0;
    seed = 17'h1_2960;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(a_rc, 8'h00);
    rd(a_pin, 8'h00);
    rd(a_mk, 8'h00);
    wr(a_rc, 8'h5a);
    rd(a_rc, 8'h5a);
    wr(12'h123, 8'hff);
    rd(12'h123, 8'h00);
    $display("register test done");
    for (int p = 1; p < 7; p++)
      rx_run(p[7:0]);
    tx_run(8'h01);
    tx_run(8'h04);
    wr(a_st, 8'h0f);
    wr(a_mk, 8'h01);
    wr(a_rc, 8'h02);
    wr(a_pin, 8'h00);
    pulse(8'h24);
    @(negedge clk_i);
    chk({irq, pins.port_frame_out}, 8'h03);
    rd(a_st, 8'h01);
    wr(a_st, 8'h01);
    @(negedge clk_i);
    chk(irq, 8'h00);
    wr(a_rc, 8'h00);
    wr(a_pin, 8'h07);
    rx_st <= 1'b1;
    @(posedge clk_i);
    ev <= 8'h01;
    @(negedge clk_i);
    s = seed[4:1];
    @(posedge clk_i);
    ev <= 8'h00;
    @(negedge clk_i);
    chk({pins.port_clock_out, pins.port_tx_data_in_oe, pins.rx_enable_pin_b,
      pins.rx_enable_pin_a, pins.port_tx_data_in_drive, pins.port_rx_data_out}, {2'b11, s});
    $display("irq and symbol test done");
    test_done();
  end
endmodule
